//--- pkg/sfcr_cfg.svh
// Constants of the sensor front end register bank
`ifndef SFCR_CFG_SVH
`define SFCR_CFG_SVH
`define SFCR_ID_VALUE 16'h5a5a
`define SFCR_CMD_ID 8'h01
`define SFCR_CMD_STAT 8'h02
`define SFCR_CMD_I 8'h03
`define SFCR_CMD_Q 8'h04
`define SFCR_CMD_DONE 8'h05
`define SFCR_CMD_DIV 8'h20
`define SFCR_CMD_FREQ 8'h21
`define SFCR_CMD_AMP 8'h22
`define SFCR_CMD_MUX 8'h23
`define SFCR_CMD_ATT 8'h24
`define SFCR_CMD_TIA 8'h25
`define SFCR_CMD_DEMOD_CLOCK_ROUTING 8'h26
`define SFCR_CMD_CTL 8'h2a
`define SFCR_CMD_PAIR 8'h90
`define SFCR_WR_NIB 4'h3
`define SFCR_RD_NIB 4'h2
`define SFCR_BITS_CMD 6'h08
`define SFCR_BITS_WORD 6'h18
`define SFCR_BITS_MAX 6'h28
`define SFCR_DIV_BASE 4'hc
`define SFCR_DIV_LAST 4'hb
`define SFCR_OTP_CYCLES 8190
`define SFCR_AMP_OFF_LO 2'h0
`define SFCR_AMP_OFF_HI 2'h3
`define SFCR_SEN_LAST 4'h9
`define SFCR_SEN_COMP 4'hb
`define SFCR_MODE_DRIVE 2'h1
`define SFCR_ST_START1 2'h1
`define SFCR_ST_CONT 2'h2
`define SFCR_ST_RESET 2'h0
`define SFCR_ACC_8 2'h1
`define SFCR_ACC_16 2'h2
`define SFCR_N4 5'h04
`define SFCR_N8 5'h08
`define SFCR_N16 5'h10
`define SFCR_SAMPLE_W 10
`define SFCR_ACC_W 14
`endif

//--- pkg/sfcr_pkg.sv
// Types of the sensor front end register bank
package sfcr_pkg;
	typedef enum logic [1:0] {
		SFCR_IDLE = 2'b01,
		SFCR_RUN = 2'b10
	} sfcr_conv_t;
endpackage

//--- verilog/sfcr_regs.sv
// SPI register bank of the capacitive sensing front end
//
// Contract
// - Results carry 12 to 14 bits by accumulation
// - Command 0x90 returns both results together
// - Done bit 0 of 0x05 sets after load
// - Done clears on 0x90 or new conversion
// - Divider written 0x30, read 0x20, applied
// - Code 0 is /12, down to /1
// - Divider resets to code zero, /12
// - Divided enable drives all but SPI; the decoded analog controls update on every system clock
// - Divider change triggers memory reload
// - Reload under 8190 cycles, blocks sensing; only a start waits, a conversion already running goes on
// - Frequency field 0x31/0x21, resets zero
// - Amplitude field 0x32/0x22, 00/11 disable
// - Overvoltage flags invalid for amplitude 00/11
// - Mux register: mode, channel, zero top
// - Channel codes pick pins, compensation, none
// - Mode: open, driver, common, no-op
// - Attenuation field 0x34/0x24
// - Transimpedance gain field 0x35/0x25
// - Demod routing: swap and invert bits
// - Status bits 15:13 mirror divider bits 2:0
// - 4/8/16 samples give 12/13/14 bits
`timescale 1ns/1ps
`default_nettype none
`include "sfcr_cfg.svh"
module sfcr_regs
	import sfcr_pkg::*;
#(
	parameter int OTP_RELOAD_CYCLES = `SFCR_OTP_CYCLES - 1
) (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic spi_sclk_in,
	input wire logic spi_cs_n_in,
	input wire logic spi_mosi_in,
	output logic spi_miso_out,
	input wire logic adc_valid_in,
	input wire logic [`SFCR_SAMPLE_W-1:0] adc_i_in,
	input wire logic [`SFCR_SAMPLE_W-1:0] adc_q_in,
	input wire logic driver_overvoltage_flag_in,
	input wire logic compensation_overvoltage_flag_in,
	output logic mclk_en_out,
	output logic otp_reload_out,
	output logic otp_busy_out,
	output logic conv_done_out,
	output logic [3:0] ext_clock_divider_out,
	output logic [1:0] excitation_frequency_out,
	output logic [1:0] driver_amplitude_out,
	output logic driver_enable_out,
	output logic [1:0] connection_mode_out,
	output logic [3:0] channel_select_out,
	output logic [9:0] sensor_pin_enable_out,
	output logic compensation_pin_enable_out,
	output logic [1:0] compensation_attenuation_out,
	output logic [1:0] transimpedance_gain_out,
	output logic demod_swap_out,
	output logic demod_invert_out
);
	logic sclk_q;
	logic [5:0] bit_cnt;
	logic [7:0] cmd;
	logic [15:0] rx;
	logic [31:0] tx;
	logic [7:0] conversion_control;
	logic [15:0] in_phase_result;
	logic [15:0] quadrature_result;
	logic [3:0] div_cnt;
	logic [13:0] otp_cnt;
	logic conv_pending;
	sfcr_conv_t conv_state;
	logic [4:0] smp_cnt;
	logic [`SFCR_ACC_W-1:0] acc_i;
	logic [`SFCR_ACC_W-1:0] acc_q;
	logic sclk_rise;
	logic sclk_fall;
	logic [7:0] next_cmd;
	logic cmd_done;
	logic word_done;
	logic wr_hit;
	logic [7:0] wr_addr;
	logic [15:0] wr_data;
	logic [15:0] status_word;
	logic [31:0] rd_data;
	logic [3:0] div_ratio;
	logic div_change;
	logic start_wr;
	logic stop_wr;
	logic conv_begin;
	logic conv_finish;
	logic [4:0] smp_target;

	// SCLK is sampled as a plain input, so it must be slow against clk
	assign sclk_rise = spi_sclk_in && !sclk_q;
	assign sclk_fall = !spi_sclk_in && sclk_q;
	assign next_cmd = {cmd[6:0], spi_mosi_in};
	assign cmd_done = sclk_rise && (bit_cnt == `SFCR_BITS_CMD - 6'h01);
	assign word_done = sclk_rise && (bit_cnt == `SFCR_BITS_WORD - 6'h01);
	assign wr_hit = word_done && (cmd[7:4] == `SFCR_WR_NIB);
	assign wr_addr = {`SFCR_RD_NIB, cmd[3:0]};
	// The last data bit is still on MOSI at the write edge, rx is one short
	assign wr_data = {rx[14:0], spi_mosi_in};

	// SPI edge tracking and bit counting
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			sclk_q <= 1'b0;
			bit_cnt <= 6'h00;
			cmd <= 8'h00;
			rx <= 16'h0000;
		end else begin
			sclk_q <= spi_sclk_in;
			if (spi_cs_n_in) begin
				bit_cnt <= 6'h00;
			end else if (sclk_rise) begin
				if (bit_cnt != `SFCR_BITS_MAX)
					bit_cnt <= bit_cnt + 6'h01;
				if (bit_cnt < `SFCR_BITS_CMD)
					cmd <= next_cmd;
				else
					rx <= {rx[14:0], spi_mosi_in};
			end
		end
	end

	// Status word: flags are masked while the driver is off
	always_comb begin
		status_word = 16'h0000;
		status_word[15:13] = ext_clock_divider_out[2:0];
		if (driver_amplitude_out != `SFCR_AMP_OFF_LO &&
			driver_amplitude_out != `SFCR_AMP_OFF_HI) begin
			status_word[5] = driver_overvoltage_flag_in;
			status_word[4] = compensation_overvoltage_flag_in;
		end
	end

	// Read mux; unmapped commands shift out zeros
	always_comb begin
		rd_data = 32'h00000000;
		unique case (next_cmd)
			`SFCR_CMD_ID: rd_data[31:16] = `SFCR_ID_VALUE;
			`SFCR_CMD_STAT: rd_data[31:16] = status_word;
			`SFCR_CMD_I: rd_data[31:16] = in_phase_result;
			`SFCR_CMD_Q: rd_data[31:16] = quadrature_result;
			`SFCR_CMD_DONE: rd_data[16] = conv_done_out;
			`SFCR_CMD_DIV: rd_data[19:16] = ext_clock_divider_out;
			`SFCR_CMD_FREQ: rd_data[17:16] = excitation_frequency_out;
			`SFCR_CMD_AMP: rd_data[17:16] = driver_amplitude_out;
			`SFCR_CMD_MUX: rd_data[21:16] =
				{channel_select_out, connection_mode_out};
			`SFCR_CMD_ATT: rd_data[17:16] = compensation_attenuation_out;
			`SFCR_CMD_TIA: rd_data[17:16] = transimpedance_gain_out;
			`SFCR_CMD_DEMOD_CLOCK_ROUTING: rd_data[17:16] =
				{demod_invert_out, demod_swap_out};
			`SFCR_CMD_CTL: rd_data[23:16] = conversion_control;
			`SFCR_CMD_PAIR: rd_data = {in_phase_result,
				quadrature_result};
			default: rd_data = 32'h00000000;
		endcase
	end

	// Shift out MSB first, changing on the falling SCLK edge
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			tx <= 32'h00000000;
			spi_miso_out <= 1'b0;
		end else if (cmd_done) begin
			tx <= rd_data;
		end else if (sclk_fall && !spi_cs_n_in) begin
			spi_miso_out <= tx[31];
			tx <= {tx[30:0], 1'b0};
		end
	end

	// Configuration registers written by 0x3n commands
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			ext_clock_divider_out <= 4'h0;
			excitation_frequency_out <= 2'h0;
			driver_amplitude_out <= 2'h0;
			connection_mode_out <= 2'h0;
			channel_select_out <= 4'h0;
			compensation_attenuation_out <= 2'h0;
			transimpedance_gain_out <= 2'h0;
			demod_swap_out <= 1'b0;
			demod_invert_out <= 1'b0;
			conversion_control <= 8'h00;
		end else if (wr_hit) begin
			unique case (wr_addr)
				`SFCR_CMD_DIV: ext_clock_divider_out <= wr_data[3:0];
				`SFCR_CMD_FREQ: excitation_frequency_out <= wr_data[1:0];
				`SFCR_CMD_AMP: driver_amplitude_out <= wr_data[1:0];
				`SFCR_CMD_MUX: begin
					connection_mode_out <= wr_data[1:0];
					channel_select_out <= wr_data[5:2];
				end
				`SFCR_CMD_ATT: compensation_attenuation_out <= wr_data[1:0];
				`SFCR_CMD_TIA: transimpedance_gain_out <= wr_data[1:0];
				`SFCR_CMD_DEMOD_CLOCK_ROUTING: begin
					demod_swap_out <= wr_data[0];
					demod_invert_out <= wr_data[1];
				end
				`SFCR_CMD_CTL: conversion_control <= wr_data[7:0];
				default: ;
			endcase
		end
	end

	// Decoded analog controls, one cycle behind the fields
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			sensor_pin_enable_out <= 10'h000;
			compensation_pin_enable_out <= 1'b0;
			driver_enable_out <= 1'b0;
		end else begin
			sensor_pin_enable_out <= 10'h000;
			if (channel_select_out <= `SFCR_SEN_LAST)
				sensor_pin_enable_out[channel_select_out] <= 1'b1;
			compensation_pin_enable_out <=
				(channel_select_out == `SFCR_SEN_COMP);
			driver_enable_out <= driver_amplitude_out != `SFCR_AMP_OFF_LO &&
				driver_amplitude_out != `SFCR_AMP_OFF_HI;
		end
	end

	// Ratio from code: 0 gives 12, each step one less, floor of 1
	assign div_ratio = (ext_clock_divider_out > `SFCR_DIV_LAST) ? 4'h1 :
		`SFCR_DIV_BASE - ext_clock_divider_out;

	// Internal clock as an enable pulse; SPI above ignores it
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			div_cnt <= 4'h0;
			mclk_en_out <= 1'b0;
		end else if (div_cnt >= div_ratio - 4'h1) begin
			div_cnt <= 4'h0;
			mclk_en_out <= 1'b1;
		end else begin
			div_cnt <= div_cnt + 4'h1;
			mclk_en_out <= 1'b0;
		end
	end

	// Only a write that really changes the divider code restarts the reload
	assign div_change = wr_hit && wr_addr == `SFCR_CMD_DIV &&
		wr_data[3:0] != ext_clock_divider_out;

	// Memory reload sequencer, counted in internal clock enables
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			otp_busy_out <= 1'b0;
			otp_reload_out <= 1'b0;
			otp_cnt <= 14'h0000;
		end else begin
			otp_reload_out <= div_change;
			if (div_change) begin
				otp_busy_out <= 1'b1;
				otp_cnt <= 14'h0000;
			end else if (otp_busy_out && mclk_en_out) begin
				if (otp_cnt == 14'(OTP_RELOAD_CYCLES - 1))
					otp_busy_out <= 1'b0;
				otp_cnt <= otp_cnt + 14'h0001;
			end
		end
	end

	// Start and stop requests from the conversion control write
	assign start_wr = wr_hit && wr_addr == `SFCR_CMD_CTL &&
		(wr_data[1:0] == `SFCR_ST_START1 || wr_data[1:0] == `SFCR_ST_CONT);
	assign stop_wr = wr_hit && wr_addr == `SFCR_CMD_CTL && !start_wr;
	// A start waits here while the reload runs
	assign conv_begin = conv_pending && !otp_busy_out && mclk_en_out &&
		conv_state == SFCR_IDLE;

	// Sample count per accumulation setting
	always_comb begin
		unique case (conversion_control[5:4])
			`SFCR_ACC_8: smp_target = `SFCR_N8;
			`SFCR_ACC_16: smp_target = `SFCR_N16;
			default: smp_target = `SFCR_N4;
		endcase
	end
	assign conv_finish = conv_state == SFCR_RUN && mclk_en_out &&
		adc_valid_in && smp_cnt == smp_target - 5'h01;

	// Conversion sequencer and accumulators on the internal clock
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			conv_pending <= 1'b0;
			conv_state <= SFCR_IDLE;
			smp_cnt <= 5'h00;
			acc_i <= '0;
			acc_q <= '0;
		end else if (stop_wr) begin
			conv_pending <= 1'b0;
			conv_state <= SFCR_IDLE;
			smp_cnt <= 5'h00;
		end else begin
			if (start_wr)
				conv_pending <= 1'b1;
			unique case (conv_state)
				SFCR_IDLE: if (conv_begin) begin
					conv_pending <= start_wr;
					conv_state <= SFCR_RUN;
					smp_cnt <= 5'h00;
					acc_i <= '0;
					acc_q <= '0;
				end
				SFCR_RUN: if (mclk_en_out && adc_valid_in) begin
					acc_i <= acc_i + `SFCR_ACC_W'(adc_i_in);
					acc_q <= acc_q + `SFCR_ACC_W'(adc_q_in);
					smp_cnt <= smp_cnt + 5'h01;
					if (conv_finish) begin
						smp_cnt <= 5'h00;
						acc_i <= '0;
						acc_q <= '0;
						if (conversion_control[1:0] != `SFCR_ST_CONT)
							conv_state <= SFCR_IDLE;
					end
				end
			endcase
		end
	end

	// Results load zero extended, so short results sit right aligned
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			in_phase_result <= 16'h0000;
			quadrature_result <= 16'h0000;
		end else if (conv_finish) begin
			in_phase_result <= 16'(acc_i + `SFCR_ACC_W'(adc_i_in));
			quadrature_result <= 16'(acc_q + `SFCR_ACC_W'(adc_q_in));
		end
	end

	// Done flag: a finish in the same cycle as a clear still sets it
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in)
			conv_done_out <= 1'b0;
		else if (conv_finish)
			conv_done_out <= 1'b1;
		else if ((cmd_done && next_cmd == `SFCR_CMD_PAIR) || conv_begin)
			conv_done_out <= 1'b0;
	end

	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);

	a_div_five: assert property ((mclk_en_out && ext_clock_divider_out ==
		4'h7) ##1 (ext_clock_divider_out == 4'h7)[*4] |=> mclk_en_out)
		else $error("divide by five period wrong");
	a_div_one: assert property ((ext_clock_divider_out >= 4'hc) ##1
		(ext_clock_divider_out >= 4'hc) |-> mclk_en_out)
		else $error("divide by one not every cycle");
	a_done_set: assert property (conv_finish |=> conv_done_out &&
		in_phase_result[15:14] == 2'h0)
		else $error("done or result wrong after finish");
	a_done_clear: assert property ((cmd_done && next_cmd == 8'h90 &&
		!conv_finish) |=> !conv_done_out)
		else $error("pair read did not clear done");
	a_reload_go: assert property (div_change |=> otp_busy_out &&
		otp_reload_out)
		else $error("divider change missed reload");
	a_reload_blocks: assert property ($rose(conv_state == SFCR_RUN) |->
		!$past(otp_busy_out))
		else $error("conversion began during reload");
	a_reload_len: assert property (otp_busy_out |->
		otp_cnt < 14'(OTP_RELOAD_CYCLES))
		else $error("reload ran too long");
	a_flag_mask: assert property ((driver_amplitude_out == 2'h0 ||
		driver_amplitude_out == 2'h3) |-> status_word[5:4] == 2'h0)
		else $error("overvoltage flag shown while driver off");
	a_pin_decode: assert property ((channel_select_out == 4'hb) ##1
		$stable(channel_select_out) |-> compensation_pin_enable_out &&
		sensor_pin_enable_out == 10'h000)
		else $error("compensation pin decode wrong");
	a_width_four: assert property ((conv_finish &&
		conversion_control[5:4] == 2'h0) |=> in_phase_result[15:12] == 4'h0)
		else $error("four sample result wider than 12 bits");
endmodule
`default_nettype wire

//--- bench/sfcr_host.sv
// Host controller model: SPI master in mode 0 for the register bank
`timescale 1ns/1ps
`default_nettype none
module sfcr_host (
	input wire logic clk_in,
	input wire logic miso_in,
	output logic sclk_out,
	output logic cs_n_out,
	output logic mosi_out
);
	// Idle bus: chip deselected, clock low between frames
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		mosi_out = 1'b0;
	end

	// Four system clocks a half period, above the two the slave needs
	task automatic half();
		repeat (4) @(posedge clk_in);
		#1;
	endtask

	// Command byte then n data bits, MSB first; read bits shift into rd
	task automatic xfer(input logic [7:0] c, input logic [31:0] wd,
		input int n, output logic [31:0] rd);
		logic [39:0] sh;
		int i;
		sh = (n == 16) ? {c, wd[15:0], 16'h0} : {c, wd};
		rd = 32'h0;
		@(posedge clk_in);
		#1;
		cs_n_out = 1'b0;
		for (i = 0; i < n + 8; i++) begin
			mosi_out = sh[39-i];
			half();
			sclk_out = 1'b1;
			rd = (i < 8) ? rd : {rd[30:0], miso_in};
			half();
			sclk_out = 1'b0;
		end
		half();
		cs_n_out = 1'b1;
		// Released line flips so a stale bit is never mistaken for data
		mosi_out = ~mosi_out;
		half();
	endtask
endmodule
`default_nettype wire

//--- bench/sensor_frontend_config_regs_tb.sv
// Self-checking bench for the sensor front end register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
	err_count++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
	end end
module sensor_frontend_config_regs_tb import sfcr_pkg::*;;
	logic clk_sys_in = 1'b0;
	logic reset_in = 1'b1;
	logic sclk, cs_n, mosi, miso, mclk_en, reload, busy, done;
	logic adc_valid = 1'b1;
	logic [9:0] adc_i = 10'h3ff;
	logic [9:0] adc_q = 10'h155;
	logic ov_drv = 1'b0;
	logic ov_cmp = 1'b0;
	int n_reload = 0;
	logic [3:0] div_o, ch_o;
	logic [1:0] freq_o, amp_o, mode_o, att_o, tia_o;
	logic [9:0] pin_o;
	logic drv_en, comp_o, swap_o, inv_o;
	logic [15:0] d, x;
	logic [31:0] r, x32;
	int err_count = 0;
	int n_tests = 0;

	// Reload cut short, yet long enough to catch a start during it
	sfcr_regs #(.OTP_RELOAD_CYCLES(64)) dut (
		.clk_sys_in(clk_sys_in), .reset_in(reset_in),
		.spi_sclk_in(sclk), .spi_cs_n_in(cs_n), .spi_mosi_in(mosi),
		.spi_miso_out(miso), .adc_valid_in(adc_valid), .adc_i_in(adc_i),
		.adc_q_in(adc_q), .driver_overvoltage_flag_in(ov_drv),
		.compensation_overvoltage_flag_in(ov_cmp), .mclk_en_out(mclk_en),
		.otp_reload_out(reload), .otp_busy_out(busy),
		.conv_done_out(done), .ext_clock_divider_out(div_o),
		.excitation_frequency_out(freq_o), .driver_amplitude_out(amp_o),
		.driver_enable_out(drv_en), .connection_mode_out(mode_o),
		.channel_select_out(ch_o), .sensor_pin_enable_out(pin_o),
		.compensation_pin_enable_out(comp_o),
		.compensation_attenuation_out(att_o),
		.transimpedance_gain_out(tia_o), .demod_swap_out(swap_o),
		.demod_invert_out(inv_o));
	sfcr_host host (.clk_in(clk_sys_in), .miso_in(miso), .sclk_out(sclk),
		.cs_n_out(cs_n), .mosi_out(mosi));

	always #5 clk_sys_in = ~clk_sys_in;

	// Count of one-cycle reload pulses; tasks compare before and after
	always @(posedge clk_sys_in) begin
		if (reload === 1'b1) n_reload <= n_reload + 1;
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// Bounded wait: 0 clock enable, 1 reload busy, 2 done flag
	task automatic wt(input int s, input logic v);
		int i;
		for (i = 0; i < 4000; i++) begin
			@(posedge clk_sys_in);
			#1;
			if ((s == 0 ? mclk_en : s == 1 ? busy : done) === v) return;
		end
		`CHK("wait", v, ~v)
		conclude();
	endtask

	task automatic wr(input logic [7:0] c, input logic [15:0] v);
		host.xfer(c, {16'h0, v}, 16, r);
	endtask

	task automatic rd16(input logic [7:0] c);
		host.xfer(c, 32'h0, 16, r);
		d = r[15:0];
	endtask

	task automatic t_reset();
		int a;
		for (a = 8'h20; a < 8'h27; a++) begin
			rd16(8'(a));
			`CHK("reset value", 16'h0, d)
		end
		rd16(8'h05);
		`CHK("done at reset", 16'h0, d)
		$display("test reset finished");
	endtask

	// Every divider code; code 0 repeats the reset value so no reload
	task automatic t_div();
		int c, p, q;
		for (c = 0; c < 16; c++) begin
			q = n_reload;
			wr(8'h30, 16'(c));
			`CHK("reload", c != 0, n_reload != q)
			rd16(8'h20);
			`CHK("divider", 16'(c), d)
			`CHK("divider port", 4'(c), div_o)
			rd16(8'h02);
			`CHK("status mirror", {3'(c), 13'h0}, d)
			wt(1, 1'b0);
			wt(0, 1'b1);
			p = 0;
			do begin
				@(posedge clk_sys_in);
				#1;
				p++;
			end while (mclk_en !== 1'b1 && p < 20);
			`CHK("period", c > 11 ? 1 : 12 - c, p)
		end
		$display("test divider finished");
	endtask

	// All ones then a mid value through every field register
	task automatic t_fields();
		int a, k;
		logic [15:0] pv;
		for (k = 0; k < 2; k++) begin
			for (a = 8'h31; a < 8'h37; a++) begin
				wr(8'(a), k ? 16'h0002 : 16'hffff);
				rd16(8'(a - 16));
				x = k ? 16'h2 : a == 8'h33 ? 16'h3f : 16'h3;
				`CHK("field", x, d)
			end
			pv = {freq_o, amp_o, ch_o, mode_o, att_o, tia_o, inv_o, swap_o};
			`CHK("ports", k ? 16'ha0aa : 16'hffff, pv)
		end
		$display("test fields finished");
	endtask

	task automatic t_mux();
		int c;
		for (c = 0; c < 16; c++) begin
			wr(8'h33, {10'h0, 4'(c), 2'b01});
			`CHK("pins", c < 10 ? 10'h1 << c : 10'h0, pin_o)
			`CHK("comp pin", c == 11, comp_o)
		end
		$display("test mux finished");
	endtask

	// Overvoltage flags show only for the two driving amplitudes
	task automatic t_status();
		int c;
		ov_drv = 1'b1;
		ov_cmp = 1'b1;
		for (c = 0; c < 4; c++) begin
			wr(8'h32, 16'(c));
			rd16(8'h02);
			x = (c == 1 || c == 2) ? 16'he030 : 16'he000;
			`CHK("overvoltage mask", x, d)
		end
		$display("test status finished");
	endtask

	// Single conversions at each accumulation code, read as a pair
	task automatic t_conv();
		int a, n;
		for (a = 0; a < 4; a++) begin
			n = a == 1 ? 8 : a == 2 ? 16 : 4;
			wr(8'h3a, {10'h0, 2'(a), 4'h1});
			wt(2, 1'b1);
			rd16(8'h05);
			`CHK("done bit", 16'h1, d)
			host.xfer(8'h90, 32'h0, 32, r);
			x32 = {16'(n * 1023), 16'(n * 341)};
			`CHK("result pair", x32, r)
			`CHK("done cleared", 1'b0, done)
		end
		$display("test conversion finished");
	endtask

	// Start held off by a reload, restart, continuous run, then stop
	task automatic t_restart();
		wr(8'h30, 16'h0000); // Code a host picks for /12
		wr(8'h3a, 16'h0001);
		`CHK("busy at start", 1'b1, busy)
		`CHK("no early done", 1'b0, done)
		wt(2, 1'b1);
		`CHK("reload over", 1'b0, busy)
		adc_valid = 1'b0;
		wr(8'h3a, 16'h0002);
		repeat (24) @(posedge clk_sys_in);
		#1;
		`CHK("restart clears done", 1'b0, done)
		adc_valid = 1'b1;
		wt(2, 1'b1);
		host.xfer(8'h90, 32'h0, 32, r);
		`CHK("continuous pair", 32'h0ffc0554, r)
		`CHK("done sets again", 1'b1, done)
		wr(8'h3a, 16'h0003);
		host.xfer(8'h90, 32'h0, 32, r);
		`CHK("stopped done", 1'b0, done)
		$display("test restart finished");
	endtask

	initial begin
		repeat (20) @(posedge clk_sys_in);
		#1;
		reset_in = 1'b0;
		t_reset();
		t_div();
		t_fields();
		t_mux();
		t_status();
		t_conv();
		t_restart();
		conclude();
	end
endmodule
`default_nettype wire
